/* File: design/osc_stab_consts.vh */
`ifndef OSC_STAB_CONSTS_VH
`define OSC_STAB_CONSTS_VH
// Register byte addresses on the AXI4-Lite slave.
`define REG_WAIT_SEL      12'h000
`define REG_STATUS        12'h004
`define REG_CTRL          12'h008
`define REG_IRQ_STAT      12'h00C
`define REG_IRQ_MASK      12'h010
// Control register fields.
`define CTRL_EXT_PICK     0
`define CTRL_PIN_PICK     1
`define CTRL_STOP_REQ     2
`define CTRL_CPU_XTAL     3
// Reset values.
`define WAIT_SEL_RST      3'h5
`define CTRL_RST          4'h0
// Interrupt event bits.
`define IRQ_DONE          0
`define IRQ_ORDER_ERR     1
`define IRQ_POWER_OK      2
// Power-on stabilization time in microseconds, least and most.
`define PON_MIN_US        1930
`define PON_MAX_US        5390
`define CLK_MHZ           25
// Cycles at 25 MHz, least rounded up.
`define PON_MIN_CYC       ((`PON_MIN_US * `CLK_MHZ))
`define PON_MAX_CYC       ((`PON_MAX_US * `CLK_MHZ))
// Counter width and number of elapsed-time thresholds.
`define CNT_W             18
`define NUM_STEPS         8
`endif

/* File: design/stab_counter.v */
`timescale 1ns/1ps
`include "osc_stab_consts.vh"
// Elapsed-time counter with a thermometer status of passed thresholds.
module stab_counter #(
    parameter CNT_W = `CNT_W,
    parameter STEPS = `NUM_STEPS,
    parameter SHIFT0 = 8
) (
    // Clock and reset.
    input  wire             clk,
    input  wire             reset,
    // Control.
    input  wire             clear,
    input  wire             run,
    input  wire [2:0]       limit_sel,
    // Results.
    output reg  [STEPS-1:0] elapsed_r,
    output reg              reached_r
);
    reg  [CNT_W-1:0] count_r;
    wire [STEPS-1:0] passed;
    wire [STEPS-1:0] limit_mask;

    // Each threshold doubles the previous one, so one count serves all steps.
    genvar g;
    generate
        for (g = 0; g < STEPS; g = g + 1) begin : step
            assign passed[g]     = (count_r >= ((1 << (SHIFT0 + g)) - 1));
            assign limit_mask[g] = (g <= limit_sel);
        end
    endgenerate

    // Count stops at the selected limit; bits fill upward and stay set.
    always @(posedge clk) begin
        if (reset || clear) begin
            count_r   <= {CNT_W{1'b0}};
            elapsed_r <= {STEPS{1'b0}};
            reached_r <= 1'b0;
        end else if (run && !reached_r) begin
            count_r   <= count_r + 1'b1;
            elapsed_r <= elapsed_r | (passed & limit_mask);
            reached_r <= passed[limit_sel];
        end
    end
endmodule // stab_counter

/* File: design/osc_stab_ctrl.v */
`timescale 1ns/1ps
`include "osc_stab_consts.vh"
module osc_stab_ctrl #(
    parameter PON_CYCLES = `PON_MIN_CYC
) (
    // Clock and reset.
    input  wire        clk,
    input  wire        reset,
    // AXI4-Lite write address.
    input  wire [11:0] s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    // AXI4-Lite write data.
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    // AXI4-Lite write response.
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // AXI4-Lite read address.
    input  wire [11:0] s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    // AXI4-Lite read data.
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // Oscillator side.
    input  wire        supply_ok,
    input  wire        osc_running,
    input  wire        stop_release,
    // System side.
    output reg         sys_reset_hold_r,
    output reg         cpu_clk_enable_r,
    output reg         osc_pins_active_r,
    output reg         ext_clk_pins_active_r,
    output reg         irq_r
);
    // Software-visible register storage.
    reg  [2:0]  stab_wait_select_r;
    reg  [3:0]  ctrl_r;
    reg  [2:0]  irq_stat_r;
    reg  [2:0]  irq_mask_r;
    // Power-on hold sequencing.
    reg  [22:0] pon_cnt_r;
    reg         pon_done_r;
    // STOP and stabilization sequencing.
    reg         waiting_r;
    reg         counting_r;
    reg         in_stop_r;
    // Write channel holding registers, so address and data may arrive apart.
    reg  [11:0] awaddr_r;
    reg  [31:0] wdata_r;
    reg         aw_have_r;
    reg         w_have_r;
    // Combinational helpers.
    reg  [2:0]  irq_set;
    reg  [31:0] rdata_nxt;
    reg         rd_err;
    // Counter results and decoded strobes.
    wire [7:0]  stab_elapsed_status;
    wire        reached;
    wire        crystal_mode;
    wire        wr_fire;
    wire        rd_fire;
    wire        wr_ok;
    wire        wr_wait_sel;
    wire        wr_ctrl;
    wire        wr_mask;
    wire        ctrl_locked;

    // Crystal mode: oscillator pin function picked and no external clock.
    assign crystal_mode = ctrl_r[`CTRL_PIN_PICK] & ~ctrl_r[`CTRL_EXT_PICK];
    // A write retires once both halves are held and no response is pending.
    assign wr_fire      = aw_have_r & w_have_r & ~s_axi_bvalid;
    assign rd_fire      = s_axi_arvalid & s_axi_arready;
    // Pin selects freeze while the crystal runs, as a guard for careless code.
    assign ctrl_locked  = crystal_mode & osc_running;
    assign wr_ok        = (awaddr_r == `REG_WAIT_SEL) | (awaddr_r == `REG_CTRL) |
                          (awaddr_r == `REG_IRQ_MASK);
    // Per-register write strobes, each one cycle wide, in step with the response.
    assign wr_wait_sel  = wr_fire & (awaddr_r == `REG_WAIT_SEL);
    assign wr_ctrl      = wr_fire & (awaddr_r == `REG_CTRL);
    assign wr_mask      = wr_fire & (awaddr_r == `REG_IRQ_MASK);

    // Elapsed-time counter, cleared during STOP and running on a live crystal.
    // Its status is kept after the count ends, so software can still read it.
    stab_counter u_cnt (
        .clk       (clk),
        .reset     (reset),
        .clear     (in_stop_r),
        .run       (counting_r & osc_running),
        .limit_sel (stab_wait_select_r),
        .elapsed_r (stab_elapsed_status),
        .reached_r (reached)
    );

    // Counting follows every STOP release on a crystal, whatever clock feeds the
    // CPU, so the status shows settling up to the selected limit.
    always @(posedge clk) begin
        if (reset) begin
            counting_r <= 1'b0;
        end else if (in_stop_r) begin
            counting_r <= stop_release & crystal_mode;
        end else if (reached) begin
            counting_r <= 1'b0;
        end
    end

    // Power-on hold: reset processing waits for the stabilization count.
    // One count serves both the slow and the fast supply rise, so the hold is
    // always the least stabilization time; a supply dip starts it over.
    always @(posedge clk) begin
        if (reset || !supply_ok) begin
            pon_cnt_r        <= 23'h00_0000;
            pon_done_r       <= 1'b0;
            sys_reset_hold_r <= 1'b1;
        end else if (!pon_done_r) begin
            pon_cnt_r <= pon_cnt_r + 1'b1;
            if (pon_cnt_r >= PON_CYCLES - 1) begin
                pon_done_r       <= 1'b1;
                sys_reset_hold_r <= 1'b0;
            end
        end
    end

    // STOP and wait sequencing plus CPU clock gate.
    always @(posedge clk) begin
        if (reset) begin
            in_stop_r        <= 1'b0;
            waiting_r        <= 1'b0;
            cpu_clk_enable_r <= 1'b0;
        end else begin
            // A supply dip gates the clock at once, in step with the hold.
            if (!pon_done_r || !supply_ok) begin
                cpu_clk_enable_r <= 1'b0;
            end else if (wr_ctrl && wdata_r[`CTRL_STOP_REQ]) begin
                in_stop_r        <= 1'b1;
                cpu_clk_enable_r <= 1'b0;
            end else if (in_stop_r && stop_release) begin
                in_stop_r <= 1'b0;
                if (ctrl_r[`CTRL_CPU_XTAL] && crystal_mode) begin
                    waiting_r        <= 1'b1;
                    cpu_clk_enable_r <= 1'b0;
                end else begin
                    cpu_clk_enable_r <= 1'b1;
                end
            end else if (waiting_r && reached) begin
                waiting_r        <= 1'b0;
                cpu_clk_enable_r <= 1'b1;
            end else if (!in_stop_r && !waiting_r) begin
                cpu_clk_enable_r <= 1'b1;
            end
        end
    end

    // Event capture for the interrupt status.
    always @* begin
        irq_set = 3'h0;
        irq_set[`IRQ_DONE]      = counting_r & reached;
        irq_set[`IRQ_ORDER_ERR] = wr_wait_sel & counting_r;
        irq_set[`IRQ_POWER_OK]  = ~pon_done_r & supply_ok & (pon_cnt_r >= PON_CYCLES - 1);
    end

    // Write channel: address and data taken in either order.
    always @(posedge clk) begin
        if (reset) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'h0;
            aw_have_r     <= 1'b0;
            w_have_r      <= 1'b0;
            awaddr_r      <= 12'h000;
            wdata_r       <= 32'h0000_0000;
        end else begin
            // Ready pulses for one cycle, so each half is taken exactly once.
            s_axi_awready <= ~aw_have_r & ~s_axi_awready & s_axi_awvalid;
            s_axi_wready  <= ~w_have_r & ~s_axi_wready & s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_r <= 1'b1;
                awaddr_r  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_r <= 1'b1;
                wdata_r  <= s_axi_wdata;
            end
            if (wr_fire) begin
                aw_have_r    <= 1'b0;
                w_have_r     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? 2'h0 : 2'h2;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Register updates from the write strobes.
    always @(posedge clk) begin
        if (reset) begin
            stab_wait_select_r <= `WAIT_SEL_RST;
            ctrl_r             <= `CTRL_RST;
            irq_mask_r         <= 3'h0;
        end else begin
            if (wr_wait_sel && !counting_r) begin
                // Writes during a count are dropped so the limit cannot move.
                stab_wait_select_r <= wdata_r[2:0];
            end
            if (wr_ctrl) begin
                ctrl_r[`CTRL_CPU_XTAL] <= wdata_r[`CTRL_CPU_XTAL];
                if (!ctrl_locked) begin
                    ctrl_r[1:0] <= wdata_r[1:0];
                end
            end
            if (wr_mask) begin
                irq_mask_r <= wdata_r[2:0];
            end
        end
    end

    // Read mux.
    always @* begin
        rdata_nxt = 32'h0000_0000;
        rd_err    = 1'b0;
        case (s_axi_araddr)
            `REG_WAIT_SEL: rdata_nxt[2:0] = stab_wait_select_r;
            `REG_STATUS:   rdata_nxt[7:0] = stab_elapsed_status;
            `REG_CTRL:     rdata_nxt[3:0] = ctrl_r;
            `REG_IRQ_STAT: rdata_nxt[2:0] = irq_stat_r;
            `REG_IRQ_MASK: rdata_nxt[2:0] = irq_mask_r;
            default:       rd_err = 1'b1;
        endcase
    end

    // Read channel; no new address is taken while a response is pending.
    always @(posedge clk) begin
        if (reset) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= 2'h0;
        end else begin
            s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
            if (rd_fire) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rdata_nxt;
                s_axi_rresp  <= rd_err ? 2'h2 : 2'h0;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Sticky interrupt status cleared by its read; an event in the same cycle wins.
    always @(posedge clk) begin
        if (reset) begin
            irq_stat_r <= 3'h0;
            irq_r      <= 1'b0;
        end else begin
            if (rd_fire && s_axi_araddr == `REG_IRQ_STAT) begin
                irq_stat_r <= irq_set;
            end else begin
                irq_stat_r <= irq_stat_r | irq_set;
            end
            // A set mask bit lets its status bit through to the line.
            irq_r <= |(irq_stat_r & irq_mask_r);
        end
    end

    // Pin function follows the selects; both default to port mode.
    // Registered, so a select write shows on the pins one cycle later.
    always @(posedge clk) begin
        if (reset) begin
            osc_pins_active_r     <= 1'b0;
            ext_clk_pins_active_r <= 1'b0;
        end else begin
            osc_pins_active_r     <= crystal_mode;
            ext_clk_pins_active_r <= ctrl_r[`CTRL_PIN_PICK] & ctrl_r[`CTRL_EXT_PICK];
        end
    end
endmodule // osc_stab_ctrl

/* File: tb/osc_stab_monitor.sv */
`timescale 1ns/1ps
// Port-level checks of the stabilization controller.
module osc_stab_monitor #(
    parameter PON_CYCLES = 20
) (
    // Clock and reset.
    input wire clk,
    input wire reset,
    // Oscillator side.
    input wire supply_ok,
    input wire osc_running,
    input wire stop_release,
    // System side.
    input wire sys_reset_hold_r,
    input wire cpu_clk_enable_r,
    input wire osc_pins_active_r,
    input wire ext_clk_pins_active_r
);
    reg [15:0] on_cnt;
    reg [15:0] run_cnt;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // Supply-good cycles, and crystal cycles seen while the CPU clock is off.
    always @(posedge clk) begin
        if (reset || !supply_ok) on_cnt <= 16'h0000;
        else if (on_cnt != 16'hffff) on_cnt <= on_cnt + 16'h0001;
        if (reset || cpu_clk_enable_r) run_cnt <= 16'h0000;
        else if (osc_running && run_cnt != 16'hffff) run_cnt <= run_cnt + 16'h0001;
    end
    chk_reset_state: assert property (
        $fell(reset) |-> sys_reset_hold_r && !cpu_clk_enable_r && !osc_pins_active_r
        && !ext_clk_pins_active_r) else $error("outputs wrong after reset");
    chk_hold_supply: assert property (
        !supply_ok && sys_reset_hold_r |=> sys_reset_hold_r) else $error("hold dropped");
    chk_hold_length: assert property (
        $fell(sys_reset_hold_r) |-> on_cnt >= PON_CYCLES - 2 && on_cnt <= PON_CYCLES + 3)
        else $error("power-on hold length wrong");
    chk_cpu_gated: assert property (
        sys_reset_hold_r |-> !cpu_clk_enable_r) else $error("clock during hold");
    chk_osc_gate: assert property (
        osc_pins_active_r && !osc_running && !cpu_clk_enable_r |=> !cpu_clk_enable_r)
        else $error("clock before oscillation");
    chk_wait_min: assert property (
        $rose(cpu_clk_enable_r) && osc_pins_active_r |-> run_cnt >= 16'd254)
        else $error("crystal wait cut short");
    chk_ext_fast: assert property (
        ext_clk_pins_active_r && stop_release |-> ##[1:8] cpu_clk_enable_r)
        else $error("external clock waited");
    chk_pins_excl: assert property (
        !(osc_pins_active_r && ext_clk_pins_active_r)) else $error("both pin modes");
    cover property ($rose(cpu_clk_enable_r) && osc_pins_active_r);
    cover property (ext_clk_pins_active_r && stop_release);
    cover property ($fell(sys_reset_hold_r));
endmodule // osc_stab_monitor

bind osc_stab_ctrl osc_stab_monitor #(.PON_CYCLES(PON_CYCLES)) osc_stab_monitor_inst (
    .clk(clk), .reset(reset), .supply_ok(supply_ok), .osc_running(osc_running),
    .stop_release(stop_release), .sys_reset_hold_r(sys_reset_hold_r),
    .cpu_clk_enable_r(cpu_clk_enable_r), .osc_pins_active_r(osc_pins_active_r),
    .ext_clk_pins_active_r(ext_clk_pins_active_r));

/* File: tb/osc_source_model.sv */
`timescale 1ns/1ps
// Crystal that needs some cycles of drive before it oscillates.
module osc_source_model #(
    parameter START_DLY = 30
) (
    // Clock.
    input wire clk,
    // Drive from the pins and halt from the bench.
    input wire drive,
    input wire halt,
    // Oscillation status.
    output reg osc_running
);
    reg [7:0] age_r = 8'h00;
    initial osc_running = 1'b0;
    // Start-up delay, so a wait that counts from drive alone shows up.
    always @(posedge clk) begin
        if (!drive || halt) begin
            age_r <= 8'h00;
            osc_running <= 1'b0;
        end else if (age_r < START_DLY) age_r <= age_r + 8'h01;
        else osc_running <= 1'b1;
    end
endmodule // osc_source_model

/* File: tb/osc_stabilization_wait_control_tb.sv */
`timescale 1ns/1ps
// Drives the controller over its register bus and checks its clock gating.
module osc_stabilization_wait_control_tb;
    reg         clk, reset, supply_ok, halt, stop_release;
    reg         awvalid, wvalid, bready, arvalid, rready;
    reg  [11:0] awaddr, araddr;
    reg  [31:0] wdata, rd;
    reg  [1:0]  rs;
    reg  [45:0] rows [0:6];
    wire        awready, wready, bvalid, arready, rvalid, osc_running;
    wire        hold, cpu_en, osc_act, ext_act, irq;
    wire [1:0]  bresp, rresp;
    wire [31:0] rdata;
    integer     fails, check_count, n, i;
    time        t0;
    osc_stab_ctrl #(.PON_CYCLES(20)) osc_stab_ctrl_inst (
        .clk(clk), .reset(reset), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .supply_ok(supply_ok), .osc_running(osc_running), .stop_release(stop_release),
        .sys_reset_hold_r(hold), .cpu_clk_enable_r(cpu_en), .osc_pins_active_r(osc_act),
        .ext_clk_pins_active_r(ext_act), .irq_r(irq));
    osc_source_model #(.START_DLY(30)) osc_source_model_inst (
        .clk(clk), .drive(osc_act), .halt(halt), .osc_running(osc_running));
    // Free-running 25 MHz clock.
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task final_report;
        begin
            $display("checks %0d mismatches %0d", check_count, fails);
            if (fails == 0 && check_count > 0) $display("bench passed");
            else $display("bench failed");
            $finish;
        end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        begin
            check_count = check_count + 1;
            if (got !== exp) begin
                fails = fails + 1;
                $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task chk_in(input [31:0] got, input [31:0] lo, input [31:0] hi);
        chk((got >= lo && got <= hi) ? lo : got, lo);
    endtask
    task tick;
        begin
            @(posedge clk);
            n = n + 1;
        end
    endtask
    // Bus and CPU-clock waits are bounded; running out ends the run as a mismatch.
    task bound(input integer lim);
        if (n >= lim) begin
            fails = fails + 1;
            final_report;
        end
    endtask
    task wr(input [11:0] a, input [31:0] d);
        begin
            @(posedge clk);
            awaddr <= a;
            wdata <= d;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= 1'b1;
            n = 0;
            do begin
                tick;
                if (awready) awvalid <= 1'b0;
                if (wready) wvalid <= 1'b0;
            end while (bvalid !== 1'b1 && n < 200);
            rs = bresp;
            bready <= 1'b0;
            bound(200);
        end
    endtask
    task rd_reg(input [11:0] a);
        begin
            @(posedge clk);
            araddr <= a;
            arvalid <= 1'b1;
            rready <= 1'b1;
            n = 0;
            do begin
                tick;
                if (arready) arvalid <= 1'b0;
            end while (rvalid !== 1'b1 && n < 200);
            rd = rdata;
            rs = rresp;
            rready <= 1'b0;
            bound(200);
        end
    endtask
    // Pulse the STOP release and time the CPU clock coming back.
    task release_stop;
        begin
            @(posedge clk);
            halt <= 1'b0;
            stop_release <= 1'b1;
            t0 = $time;
            @(posedge clk);
            stop_release <= 1'b0;
        end
    endtask
    task wait_cpu;
        begin
            n = 0;
            while (cpu_en !== 1'b1 && n < 1000) tick;
            bound(1000);
        end
    endtask
    initial begin
        reset = 1'b1;
        supply_ok = 1'b0;
        halt = 1'b0;
        stop_release = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        {awaddr, araddr, wdata} = 56'h0;
        fails = 0;
        check_count = 0;
        rows[0] = {12'h000, 32'h0000_0005, 2'b00};
        rows[1] = {12'h004, 32'h0000_0000, 2'b00};
        rows[2] = {12'h008, 32'h0000_0000, 2'b00};
        rows[3] = {12'h00c, 32'h0000_0004, 2'b00};
        rows[4] = {12'h00c, 32'h0000_0000, 2'b00};
        rows[5] = {12'h014, 32'h0000_0000, 2'b10};
        rows[6] = {12'hffc, 32'h0000_0000, 2'b10};
        repeat (12) @(posedge clk);
        chk(32'({hold, cpu_en, osc_act, ext_act, irq}), 32'h0000_0010);
        reset <= 1'b0;
        supply_ok <= 1'b1;
        repeat (10) @(posedge clk);
        supply_ok <= 1'b0;
        repeat (3) @(posedge clk);
        supply_ok <= 1'b1;
        n = 0;
        while (hold !== 1'b0 && n < 100) tick;
        chk_in(n, 19, 23);
        repeat (2) @(posedge clk);
        chk(32'(cpu_en), 32'h0000_0001);
        wr(12'h010, 32'h0000_0004); // A set mask bit enables the power-on event.
        repeat (2) @(posedge clk);
        chk(32'(irq), 32'h0000_0001);
        $display("test power done");
        for (i = 0; i < 7; i = i + 1) begin
            rd_reg(rows[i][45:34]);
            chk(32'(rs), 32'(rows[i][1:0]));
            if (rows[i][1:0] == 2'b00) chk(rd, rows[i][33:2]);
        end
        repeat (2) @(posedge clk);
        chk(32'(irq), 32'h0000_0000);
        wr(12'h014, 32'h0000_0001);
        chk(32'(rs), 32'h0000_0002);
        $display("test registers done");
        wr(12'h008, 32'h0000_000b);
        wr(12'h008, 32'h0000_000f);
        chk(32'({osc_act, ext_act}), 32'h0000_0001);
        release_stop;
        wait_cpu;
        chk_in(($time - t0) / 40, 0, 8);
        $display("test external clock done");
        wr(12'h008, 32'h0000_000a);
        wr(12'h000, 32'h0000_0001);
        repeat (40) @(posedge clk);
        wr(12'h008, 32'h0000_0009);
        rd_reg(12'h008);
        chk(rd, 32'h0000_000a);
        wr(12'h008, 32'h0000_000e);
        halt <= 1'b1;
        repeat (5) @(posedge clk);
        release_stop;
        wr(12'h000, 32'h0000_0007);
        chk(32'(cpu_en), 32'h0000_0000);
        wait_cpu;
        chk_in(($time - t0) / 40, 540, 552);
        rd_reg(12'h000);
        chk(rd, 32'h0000_0001);
        rd_reg(12'h004);
        chk(rd, 32'h0000_0003);
        repeat (300) @(posedge clk);
        rd_reg(12'h004);
        chk(rd, 32'h0000_0003);
        wr(12'h010, 32'h0000_0007);
        repeat (2) @(posedge clk);
        chk(32'(irq), 32'h0000_0001);
        wr(12'h010, 32'h0000_0000);
        repeat (2) @(posedge clk);
        chk(32'(irq), 32'h0000_0000);
        rd_reg(12'h00c);
        chk(rd, 32'h0000_0003);
        $display("test crystal wait done");
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        rd_reg(12'h008);
        chk(rd, 32'h0000_0000);
        chk(32'({osc_act, ext_act}), 32'h0000_0000);
        $display("test second reset done");
        final_report;
    end
    // Last-resort guard against a hang outside the bounded waits.
    initial begin
        repeat (20000) @(posedge clk);
        fails = fails + 1;
        final_report;
    end
endmodule // osc_stabilization_wait_control_tb
